// ### core/siop_core.sv
`timescale 1ns/1ps
// Function
// - timer, osc-fail, alarm, watchdog ORed into request
// - frequency test gives 512 Hz square wave
// - main supply, level 0, test 0: pin low
// - main supply, test 1: 512 Hz conditions
// - main supply, level 1, enabled: pin follows request
// - main supply, level 1, test 0, nothing enabled: high
// - backup: only alarm and osc-fail sources
// - backup: frequency test ignored on the shared pin; variant pin still shows it
// - backup, backup enable 0: pin high
// - backup, level 1, no enables: pin high
// - backup, level 0, backup enable 1: low
// - backup: interrupts need level, backup, enable
// - level bit 7, test bit 6 calibration
// - alarm enable bit 7, backup bit 5
// - osc-fail enable, timer enable bit placement
// - main supply, level 1: pin stays low while any enabled source pending
// - variant pin shows 512 Hz under test
// - variant pin high when supply good and test off
// - supply fail clears test, asserts reset low
// - test enable starts at zero
// - osc-fail flag sticky until written zero
// - enable clear releases, re-set reasserts
module siop_core
   import siop_pkg::*;
#(
   parameter int unsigned FT_HALF = FT_HALF_CYC
) (
   // clock, reset, enable
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              clk_en,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // interrupt sources, same clock
   input  wire logic              timer_irq_pending,
   input  wire logic              alarm1_irq_pending,
   input  wire logic              watchdog_irq_pending,
   input  wire logic              watchdog_running,
   input  wire logic              osc_fail_event,
   // power state, asynchronous
   input  wire logic              backup_mode,
   input  wire logic              supply_low,
   // pins
   output logic                   shared_irq_pin_o,
   output logic                   shared_irq_pin_oe,
   output logic                   test_reset_pin
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(FT_HALF - 1);

   logic [1:0]       sync1_q;      // first stage, read by second only
   logic [1:0]       sync2_q;      // second stage
   logic [1:0]       sync3_q;      // third stage
   logic [1:0]       pwr_q;        // filtered {supply_low, backup}
   logic             bkp;          // backup table selected
   logic             vlow;         // supply below reset threshold

   logic [REG_W-1:0] calib_q;      // level and test enable
   logic [REG_W-1:0] wdog_q;       // osc-fail enable
   logic [REG_W-1:0] alm_q;        // alarm enable, backup enable
   logic [REG_W-1:0] tmr_q;        // timer enable
   logic             osc_flag_q;   // sticky osc-fail flag

   logic             out_lvl;      // discrete level bit
   logic             ft_en;        // frequency test enable
   logic             irq_m;        // main supply request
   logic             any_en_m;     // any main supply enable
   logic             irq_b;        // backup request
   logic             any_en_b;     // any backup enable
   logic             pin_low_d;    // shared pin drive low, next

   logic [CNT_W-1:0] sq_cnt_q;     // square wave divider
   logic             sq_q;         // 512 hz square wave

   logic             aw_free_q;    // address slot empty
   logic             w_free_q;     // data slot empty
   logic [ADDR_W-1:0] awaddr_q;    // held write address
   logic [REG_W-1:0] wdata_q;      // held write byte
   logic             wstrb_q;      // lane 0 strobe
   logic             bvalid_q;     // write answer pending
   logic [1:0]       bresp_q;      // write answer code
   logic             arready_q;    // read slot empty
   logic             rvalid_q;     // read answer pending
   logic [DATA_W-1:0] rdata_q;     // read answer data
   logic [1:0]       rresp_q;      // read answer code
   logic             do_wr;        // write commits this cycle
   logic             wr_hit;       // write address mapped
   logic [4:0]       wr_idx;       // write register index
   logic             rd_hit;       // read address mapped
   logic [REG_W-1:0] rd_byte;      // read mux result
   logic             pin_oe_q;     // shared pin enable
   logic             pin_o_q;      // shared pin level when driven
   logic             trp_q;        // variant pin level

   ////////////////////////////////////////////////////////////////////////
   // address decode

   // only aligned words at the five mapped indices answer okay
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic [4:0] ix;
      ix = a[6:2];
      addr_hit = (a[1:0] == 2'h0) && !a[7] &&
                 (ix == IDX_CALIB || ix == IDX_WDOG ||
                  ix == IDX_ALM1_MON || ix == IDX_FLAGS ||
                  ix == IDX_TMR_CTL);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // power state synchronisers

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         sync3_q <= 2'h0;
         pwr_q   <= 2'h0;
      end else if (clk_en) begin
         sync1_q <= {supply_low, backup_mode};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 2; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               pwr_q[i] <= sync3_q[i];
            end
         end
      end
   end

   assign bkp  = pwr_q[0];
   assign vlow = pwr_q[1];

   ////////////////////////////////////////////////////////////////////////
   // write channel

   assign do_wr  = !aw_free_q && !w_free_q && !bvalid_q;
   assign wr_idx = awaddr_q[6:2];
   assign wr_hit = addr_hit(awaddr_q);

   // address and data are taken in either order, then answered
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         aw_free_q <= 1'b1;
         w_free_q  <= 1'b1;
         awaddr_q  <= '0;
         wdata_q   <= REG_RST;
         wstrb_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else if (clk_en) begin
         if (aw_free_q && s_axi_awvalid) begin
            aw_free_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
         end
         if (w_free_q && s_axi_wvalid) begin
            w_free_q <= 1'b0;
            wdata_q  <= s_axi_wdata[REG_W-1:0];
            wstrb_q  <= s_axi_wstrb[0];
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         // slots reopen only after the answer is taken
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_free_q <= 1'b1;
            w_free_q  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   // bit placement of level, test and enables
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         calib_q <= REG_RST;
         wdog_q  <= REG_RST;
         alm_q   <= REG_RST;
         tmr_q   <= REG_RST;
      end else if (clk_en) begin
         if (do_wr && wr_hit && wstrb_q) begin
            case (wr_idx)
               IDX_CALIB:    calib_q <= wdata_q;
               IDX_WDOG:     wdog_q  <= wdata_q;
               IDX_ALM1_MON: alm_q   <= wdata_q;
               IDX_TMR_CTL:  tmr_q   <= wdata_q;
               default:      ;
            endcase
         end
         // a failing supply drops the test so the pin can signal reset
         if (vlow) begin
            calib_q[BIT_FT] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky oscillator fail flag

   // reading never clears; a new event beats a clearing write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         osc_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (osc_fail_event) begin
            osc_flag_q <= 1'b1;
         end else if (do_wr && wr_hit && wstrb_q && wr_idx == IDX_FLAGS &&
                      !wdata_q[BIT_F_OF]) begin
            osc_flag_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel

   // read mux; the flags show the pending sources, enabled or not
   always_comb begin
      rd_byte = REG_RST;
      case (s_axi_araddr[6:2])
         IDX_CALIB:    rd_byte = calib_q;
         IDX_WDOG:     rd_byte = wdog_q;
         IDX_ALM1_MON: rd_byte = alm_q;
         IDX_TMR_CTL:  rd_byte = tmr_q;
         IDX_FLAGS: begin
            rd_byte[BIT_F_WD]  = watchdog_irq_pending;
            rd_byte[BIT_F_AL1] = alarm1_irq_pending;
            rd_byte[BIT_F_TMR] = timer_irq_pending;
            rd_byte[BIT_F_OF]  = osc_flag_q;
         end
         default:      rd_byte = REG_RST;
      endcase
   end

   assign rd_hit = addr_hit(s_axi_araddr);

   // one read at a time, answered the cycle after the address
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else if (clk_en) begin
         if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_hit ? {{(DATA_W-REG_W){1'b0}}, rd_byte} : '0;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // 512 hz square wave

   // free running, so the first period after enabling the test can be short
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sq_cnt_q <= '0;
         sq_q     <= 1'b0;
      end else if (clk_en) begin
         if (sq_cnt_q == HALF_M1) begin
            sq_cnt_q <= '0;
            sq_q     <= !sq_q;
         end else begin
            sq_cnt_q <= sq_cnt_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // priority tables

   assign out_lvl = calib_q[BIT_OUT];
   assign ft_en   = calib_q[BIT_FT];

   // level request: pin stays low while any enabled source pends
   assign irq_m = (tmr_q[BIT_TIE] & timer_irq_pending) |
                  (wdog_q[BIT_OSC_FAIL_IRQ_ENABLE] & osc_flag_q) |
                  (alm_q[BIT_FIRST_ALARM_IRQ_ENABLE] & alarm1_irq_pending) |
                  (watchdog_running & watchdog_irq_pending);
   assign any_en_m = tmr_q[BIT_TIE] | wdog_q[BIT_OSC_FAIL_IRQ_ENABLE] |
                     alm_q[BIT_FIRST_ALARM_IRQ_ENABLE] | watchdog_running;
   // timer and watchdog play no part in backup
   assign irq_b = (wdog_q[BIT_OSC_FAIL_IRQ_ENABLE] & osc_flag_q) |
                  (alm_q[BIT_FIRST_ALARM_IRQ_ENABLE] & alarm1_irq_pending);
   assign any_en_b = wdog_q[BIT_OSC_FAIL_IRQ_ENABLE] | alm_q[BIT_FIRST_ALARM_IRQ_ENABLE];

   // pin drive low decision, table chosen by backup indicator
   always_comb begin
      pin_low_d = 1'b0;
      if (!bkp) begin
         if (!out_lvl && !ft_en) begin
            pin_low_d = 1'b1;
         end else if (ft_en && (!out_lvl || !any_en_m)) begin
            pin_low_d = !sq_q;
         end else if (out_lvl && any_en_m) begin
            pin_low_d = irq_m;
         end else begin
            pin_low_d = 1'b0;
         end
      end else begin
         // test enable is not looked at here
         if (!alm_q[BIT_ABE]) begin
            pin_low_d = 1'b0;
         end else if (!out_lvl) begin
            pin_low_d = 1'b1;
         end else if (!any_en_b) begin
            pin_low_d = 1'b0;
         end else begin
            pin_low_d = irq_b;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin registers

   // shared pin open drain: only ever pulls low, pull-up gives the high; variant pin drives both levels
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_oe_q <= 1'b0;
         pin_o_q  <= 1'b0;
         trp_q    <= 1'b0;
      end else if (clk_en) begin
         pin_oe_q <= pin_low_d;
         pin_o_q  <= 1'b0;
         if (vlow) begin
            trp_q <= 1'b0;
         end else if (ft_en) begin
            trp_q <= sq_q;
         end else begin
            trp_q <= 1'b1;
         end
      end
   end

   assign s_axi_awready     = aw_free_q;
   assign s_axi_wready      = w_free_q;
   assign s_axi_bvalid      = bvalid_q;
   assign s_axi_bresp       = bresp_q;
   assign s_axi_arready     = arready_q;
   assign s_axi_rvalid      = rvalid_q;
   assign s_axi_rdata       = rdata_q;
   assign s_axi_rresp       = rresp_q;
   assign shared_irq_pin_o  = pin_o_q;
   assign shared_irq_pin_oe = pin_oe_q;
   assign test_reset_pin    = trp_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   chk_main_level_low: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !bkp && !out_lvl && !ft_en) |=> shared_irq_pin_oe)
      else $error("pin not low with level and test at zero");

   chk_main_test_wave: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !bkp && ft_en && (!out_lvl || !any_en_m))
      |=> (shared_irq_pin_oe == !$past(sq_q)))
      else $error("pin does not follow test wave");

   chk_main_irq_follow: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !bkp && out_lvl && any_en_m)
      |=> (shared_irq_pin_oe == $past(irq_m)))
      else $error("pin does not follow request");

   chk_main_idle_high: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && !bkp && out_lvl && !ft_en && !any_en_m)
      |=> !shared_irq_pin_oe)
      else $error("pin not high when idle");

   chk_bkp_abe_off: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && bkp && !alm_q[BIT_ABE]) |=> !shared_irq_pin_oe)
      else $error("pin driven in backup without backup enable");

   chk_bkp_level_low: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && bkp && alm_q[BIT_ABE] && !out_lvl)
      |=> shared_irq_pin_oe)
      else $error("pin not low in backup with level zero");

   chk_bkp_irq_follow: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && bkp && alm_q[BIT_ABE] && out_lvl && any_en_b)
      |=> (shared_irq_pin_oe ==
           $past((alm_q[BIT_FIRST_ALARM_IRQ_ENABLE] & alarm1_irq_pending) |
                 (wdog_q[BIT_OSC_FAIL_IRQ_ENABLE] & osc_flag_q))))
      else $error("backup pin does not follow alarm or osc fail");

   chk_osc_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      (osc_flag_q && !(do_wr && wr_idx == IDX_FLAGS)) |=> osc_flag_q)
      else $error("osc fail flag cleared without a write");

   chk_ft_drop_fail: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && vlow) |=> (!ft_en ##0 !test_reset_pin))
      else $error("supply fail did not clear test or assert reset");

   chk_read_answer: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) // frozen
      else $error("read not answered next cycle");

endmodule // siop_core

// ### core/siop_pkg.sv
package siop_pkg;

   // timebase for the frequency test square wave
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned FT_HZ       = 512;
   localparam int unsigned FT_HALF_CYC = CLK_HZ / (2 * FT_HZ);
   localparam int unsigned CNT_W       = 16;

   // register indices; byte address is four times the index
   localparam logic [4:0] IDX_CALIB    = 5'h08;
   localparam logic [4:0] IDX_WDOG     = 5'h09;
   localparam logic [4:0] IDX_ALM1_MON = 5'h0a;
   localparam logic [4:0] IDX_FLAGS    = 5'h0f;
   localparam logic [4:0] IDX_TMR_CTL  = 5'h11;

   // bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W  = 8;

   // field positions
   localparam int unsigned BIT_OUT   = 7;
   localparam int unsigned BIT_FT    = 6;
   localparam int unsigned BIT_OSC_FAIL_IRQ_ENABLE  = 7;
   localparam int unsigned BIT_FIRST_ALARM_IRQ_ENABLE  = 7;
   localparam int unsigned BIT_ABE   = 5;
   localparam int unsigned BIT_TIE   = 5;
   localparam int unsigned BIT_F_WD  = 7;
   localparam int unsigned BIT_F_AL1 = 6;
   localparam int unsigned BIT_F_TMR = 3;
   localparam int unsigned BIT_F_OF  = 2;

   // reset values and responses
   localparam logic [7:0] REG_RST     = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### tb/siop_host.sv
`timescale 1ns/1ps
// host side of the shared pin: open drain with an external pull-up
module siop_host (
   // pin drive from the device
   input  wire logic pin_o,
   input  wire logic pin_oe,
   // level the host interrupt input sees
   output logic      pin_level
);
   ////////////////////////////////////////////////////////////////////////
   // released pin floats up to the pull-up, never to a stale value
   assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule // siop_host

// ### tb/siop_core_tb.sv
`timescale 1ns/1ps
module siop_core_tb;
   import siop_pkg::*;
   // clock, reset, bus
   logic clk_sys, rst, clk_en;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   // sources, power and pins
   logic tmr_p, alm_p, wd_p, wd_run, osc_ev, bkup, sup_low;
   logic pin_o, pin_oe, pin_level, trst_pin;
   int   fail_count, n_compared, n;
   logic [31:0] d;
   logic [1:0]  r;

   siop_core #(.FT_HALF(4)) DUT (
      .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_irq_pending(tmr_p), .alarm1_irq_pending(alm_p),
      .watchdog_irq_pending(wd_p), .watchdog_running(wd_run),
      .osc_fail_event(osc_ev), .backup_mode(bkup), .supply_low(sup_low),
      .shared_irq_pin_o(pin_o), .shared_irq_pin_oe(pin_oe),
      .test_reset_pin(trst_pin));

   siop_host u_host (.pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_level));

   ////////////////////////////////////////////////////////////////////////
   // 50 mhz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run, reached from the tests and the watchdog
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1));
      r = bresp;
      bready <= 1'b0;
   endtask

   // read: rready held high until the data beat is seen
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // power inputs pass a synchroniser, so allow a few cycles
   task automatic settle();
      repeat (8) @(posedge clk_sys);
   endtask

   // count level changes over 32 cycles on the shared or the reset pin
   task automatic toggles(input logic sel, output int cnt);
      logic p;
      cnt = 0;
      // let the caller's last edge settle so its pin update is not counted
      @(posedge clk_sys);
      p = sel ? trst_pin : pin_level;
      repeat (32) begin
         @(posedge clk_sys);
         if ((sel ? trst_pin : pin_level) !== p) cnt++;
         p = sel ? trst_pin : pin_level;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // hang guard, far beyond the few hundred cycles the tests take
   initial begin
      #1_000_000;
      fail_count++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      fail_count = 0; n_compared = 0;
      rst = 1'b1; clk_en = 1'b1; wstrb = 4'h1;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {tmr_p, alm_p, wd_p, wd_run, osc_ev, bkup, sup_low} = 7'h00;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      settle();
      chk(trst_pin, 1, "reset pin idle");
      chk(pin_level, 0, "pin low level0");
      rd(8'h20); chk(d, 0, "calib rst");
      rd(8'h24); chk(d, 0, "wdog rst");
      rd(8'h28); chk(d, 0, "alarm rst");
      rd(8'h44); chk(d, 0, "timer rst");
      rd(8'h04); chk(r, RESP_SLVERR, "unmapped rd");
      chk(d, 0, "unmapped data");
      wr(8'h04, 32'hff); chk(r, RESP_SLVERR, "unmapped wr");
      // main supply, level 1, nothing enabled
      wr(8'h20, 32'h80); chk(r, RESP_OKAY, "wr okay");
      rd(8'h20); chk(d, 32'h80, "calib");
      chk(r, RESP_OKAY, "rd okay");
      // a write with lane 0 strobe low leaves the register alone
      wstrb <= 4'h0; wr(8'h20, 32'h0); wstrb <= 4'h1;
      rd(8'h20); chk(d, 32'h80, "strobe off");
      settle(); chk(pin_level, 1, "pin high");
      // timer, alarm and watchdog each alone pull the pin
      wr(8'h44, 32'h20); rd(8'h44); chk(d, 32'h20, "timer en");
      tmr_p <= 1'b1; settle(); chk(pin_level, 0, "timer irq");
      tmr_p <= 1'b0; settle(); chk(pin_level, 1, "timer gone");
      wr(8'h44, 32'h0);
      wr(8'h28, 32'h80); rd(8'h28); chk(d, 32'h80, "alarm en");
      alm_p <= 1'b1; settle(); chk(pin_level, 0, "alarm irq");
      alm_p <= 1'b0; wr(8'h28, 32'h0);
      wd_run <= 1'b1; wd_p <= 1'b1;
      settle(); chk(pin_level, 0, "wdog irq");
      // second source while low, then service both
      wr(8'h24, 32'h80); rd(8'h24); chk(d, 32'h80, "osc en");
      osc_ev <= 1'b1; @(posedge clk_sys); osc_ev <= 1'b0;
      settle(); rd(8'h3c); chk(d, 32'h84, "flags both");
      wd_p <= 1'b0; settle(); chk(pin_level, 0, "still low");
      rd(8'h3c); chk(d, 32'h04, "osc sticky");
      wr(8'h24, 32'h0); settle(); chk(pin_level, 1, "en off");
      wr(8'h24, 32'h80); settle(); chk(pin_level, 0, "en on");
      wr(8'h3c, 32'h0); settle(); chk(pin_level, 1, "osc clr");
      rd(8'h3c); chk(d, 0, "flags clr");
      wd_run <= 1'b0;
      // frequency test on main supply
      wr(8'h24, 32'h0); wr(8'h20, 32'hc0);
      toggles(1'b0, n); chk(n >= 6, 1, "test wave");
      toggles(1'b1, n); chk(n >= 6, 1, "reset pin wave");
      wr(8'h24, 32'h80);
      toggles(1'b0, n); chk(n, 0, "irq mode steady");
      wr(8'h20, 32'h40);
      toggles(1'b0, n); chk(n >= 6, 1, "level0 wave");
      // supply failure on the variant pin
      sup_low <= 1'b1; settle(); chk(trst_pin, 0, "reset out");
      rd(8'h20); chk(d, 0, "test bit cleared");
      sup_low <= 1'b0; settle(); chk(trst_pin, 1, "supply good");
      // battery backup table
      bkup <= 1'b1; wr(8'h20, 32'h40); settle();
      chk(pin_level, 1, "no backup en");
      toggles(1'b0, n); chk(n, 0, "no wave");
      wr(8'h28, 32'h20); settle(); chk(pin_level, 0, "level0");
      wr(8'h24, 32'h0); wr(8'h20, 32'h80); settle();
      chk(pin_level, 1, "no enables");
      wr(8'h44, 32'h20); tmr_p <= 1'b1; wr(8'h28, 32'ha0); settle();
      chk(pin_level, 1, "timer off");
      alm_p <= 1'b1; settle(); chk(pin_level, 0, "alarm bk");
      alm_p <= 1'b0; settle(); chk(pin_level, 1, "alarm gone");
      bkup <= 1'b0; settle();
      chk(pin_level, 0, "main timer");
      // clock enable low freezes state: an osc-fail event is not taken
      clk_en <= 1'b0; osc_ev <= 1'b1; @(posedge clk_sys);
      osc_ev <= 1'b0; clk_en <= 1'b1;
      rd(8'h3c); chk(d[BIT_F_OF], 0, "frozen flag");
      conclude();
   end
endmodule // siop_core_tb
